// File: hdl/tcc_regs.sv
// timer, word-lane swap, free-running counter and dropped-frame counter registers
// Operation
// - Writing one to timer enable bit 29 runs the timer and clearing it halts the timer.
// - On a one-to-zero change of the enable bit the preload field is forced to FFFFh.
// - The preload field is bits 15-0 of the timer configuration, resets to FFFFh and feeds the timer counter.
// - The current count register shows the live 16-bit timer value, FFFFh after reset, upper bits zero.
// - The timer raises a periodic interrupt event at an interval set by the timer configuration.
// - Unless the swap code is held, A[1]=1 reaches the upper 16 bits and A[1]=0 the lower 16 bits.
// - With swap code 0FFFFFFFh held, A[1]=1 reaches the lower half and A[1]=0 the upper half.
// - Network-side transmit and receive always handle the lower-order half first, whatever the swap.
// - The 32-bit free-running counter starts at zero, counts once per 25MHz cycle and wraps.
// - The first half-word read of the free-running counter snapshots all 32 bits for the second read.
// - The free-running counter keeps counting in every power state D0, D1 and D2.
// - The 32-bit dropped-frame counter adds one per dropped receive frame and resets to zero.
// - The first half-word read of the dropped-frame counter returns the count and then clears it; the second read gets the snapshot.
// - An event is raised when the dropped-frame counter crosses from 7FFFFFFFh to 80000000h.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_regs #(
    parameter int TIMER_TICK_DIV = 1
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESET,
    input  wire tcc_pkg::tcc_host_bus_t HOST_BUS,
    input  wire logic                  RX_FRAME_DROPPED,
    output var  logic [15:0]           HOST_DATA_OUT,
    output var  logic                  HOST_DATA_OE,
    output var  logic                  TIMER_EVENT,
    output var  logic                  DROP_HALF_EVENT,
    output var  logic                  LANE_SWAP,
    output var  logic                  HALF_HIGH
);
    import tcc_pkg::*;

    initial begin
        if (TIMER_TICK_DIV < 1) begin
            $error("tcc_regs: TIMER_TICK_DIV must be at least 1");
        end
    end

    tcc_state_t st;
    tcc_state_t next_st;
    logic       free_tick;
    logic       timer_tick;

    ////////////////////////////////////////////////////////////////////////////
    // rate generators: 25MHz count enable from the 40MHz clock, and timer step

    tcc_rate_tick #(
        .NUM (`TCC_FREE_RUN_KHZ),
        .DEN (`TCC_SYS_CLK_KHZ)
    ) u_free_tick (
        .SYS_CLK (SYS_CLK),
        .RESET   (RESET),
        .TICK    (free_tick)
    );

    tcc_rate_tick #(
        .NUM (1),
        .DEN (TIMER_TICK_DIV)
    ) u_timer_tick (
        .SYS_CLK (SYS_CLK),
        .RESET   (RESET),
        .TICK    (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // host access decode

    logic       rd_active;
    logic       wr_active;
    logic       rd_start;
    logic       wr_start;
    logic [7:0] word_ofs;
    logic       sel_high;

    always_comb begin
        rd_active = !HOST_BUS.cs_n && !HOST_BUS.rd_n;
        wr_active = !HOST_BUS.cs_n && !HOST_BUS.wr_n;
        rd_start  = rd_active && !st.prev_rd;
        wr_start  = wr_active && !st.prev_wr;
        word_ofs  = {HOST_BUS.addr[7:2], 2'b00};
        sel_high  = HOST_BUS.addr[1] ^ st.lane_swap;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read view

    function automatic logic [15:0] pick_half(input logic [31:0] word, input logic high);
        pick_half = high ? word[31:16] : word[15:0];
    endfunction

    logic [31:0] config_view;
    logic [31:0] count_view;

    always_comb begin
        config_view = '0;
        config_view[`TCC_TIMER_EN_BIT] = st.timer_en;
        config_view[`TCC_PRELOAD_MSB:`TCC_PRELOAD_LSB] = st.timer_preload_value;
        count_view = {16'h0000, st.timer_count};
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        new_en;
        logic        drop_cleared;
        logic [31:0] drop_base;
        new_en       = st.timer_en;
        drop_cleared = 1'b0;
        drop_base    = st.dropped_frame_tally;
        next_st      = st;

        next_st.prev_rd         = rd_active;
        next_st.prev_wr         = wr_active;
        next_st.timer_event     = 1'b0;
        next_st.drop_half_event = 1'b0;
        next_st.data_oe         = rd_active;
        next_st.lane_swap       = (st.swap_word == `TCC_SWAP_CODE);
        // network-side halves stay low-first; only host lanes follow the swap
        next_st.half_high       = (rd_start || wr_start) ? sel_high : st.half_high;

        // free-running count never gated by power state
        if (free_tick) begin
            next_st.tick_count_value = st.tick_count_value + 32'h0000_0001;
        end

        // reads
        if (rd_start) begin
            unique case (word_ofs)
                `TCC_OFS_TIMER_CONFIG: begin
                    next_st.rdata = pick_half(config_view, sel_high);
                end
                `TCC_OFS_TIMER_CURRENT_COUNT: begin
                    next_st.rdata = pick_half(count_view, sel_high);
                end
                `TCC_OFS_WORD_LANE_SWAP: begin
                    next_st.rdata = pick_half(st.swap_word, sel_high);
                end
                `TCC_OFS_FREE_RUNNING_TICK: begin
                    // second half comes from the snapshot taken by the first
                    if (st.tick_snap_held) begin
                        next_st.rdata          = pick_half(st.tick_snap, sel_high);
                        next_st.tick_snap_held = 1'b0;
                    end else begin
                        next_st.rdata          = pick_half(st.tick_count_value, sel_high);
                        next_st.tick_snap      = st.tick_count_value;
                        next_st.tick_snap_held = 1'b1;
                    end
                end
                `TCC_OFS_DROPPED_RX_FRAME: begin
                    // clear on the first half; the second half reads the snapshot
                    if (st.drop_snap_held) begin
                        next_st.rdata          = pick_half(st.drop_snap, sel_high);
                        next_st.drop_snap_held = 1'b0;
                    end else begin
                        next_st.rdata          = pick_half(st.dropped_frame_tally, sel_high);
                        next_st.drop_snap      = st.dropped_frame_tally;
                        next_st.drop_snap_held = 1'b1;
                        drop_cleared           = 1'b1;
                    end
                end
                default: begin
                    next_st.rdata = 16'h0000;
                end
            endcase
        end

        // writes, one half-word at a time
        if (wr_start) begin
            unique case (word_ofs)
                `TCC_OFS_TIMER_CONFIG: begin
                    if (sel_high) begin
                        new_en = HOST_BUS.wdata[`TCC_TIMER_EN_BIT - `TCC_HALF_W];
                    end else begin
                        next_st.timer_preload_value = HOST_BUS.wdata;
                    end
                end
                `TCC_OFS_WORD_LANE_SWAP: begin
                    if (sel_high) begin
                        next_st.swap_word[31:16] = HOST_BUS.wdata;
                    end else begin
                        next_st.swap_word[15:0] = HOST_BUS.wdata;
                    end
                end
                default: begin
                    // read-only and unmapped offsets ignore writes
                end
            endcase
        end
        next_st.timer_en = new_en;

        // timer
        unique case (st.timer_state)
            TCC_TIMER_HALTED: begin
                if (new_en) begin
                    next_st.timer_state = TCC_TIMER_RUNNING;
                    next_st.timer_count = next_st.timer_preload_value;
                end
            end
            TCC_TIMER_RUNNING: begin
                if (!new_en) begin
                    next_st.timer_state         = TCC_TIMER_HALTED;
                    next_st.timer_preload_value = `TCC_PRELOAD_RESET;
                end else if (timer_tick) begin
                    if (st.timer_count == `TCC_TIMER_ZERO) begin
                        next_st.timer_count = st.timer_preload_value;
                        next_st.timer_event = 1'b1;
                    end else begin
                        next_st.timer_count = st.timer_count - 16'h0001;
                    end
                end
            end
            default: begin
                next_st.timer_state = TCC_TIMER_HALTED;
            end
        endcase

        // dropped frames: a drop in the clearing cycle is kept
        if (drop_cleared) begin
            drop_base = `TCC_DROP_RESET;
        end
        if (RX_FRAME_DROPPED) begin
            next_st.dropped_frame_tally = drop_base + 32'h0000_0001;
            if (drop_base + 32'h0000_0001 == `TCC_DROP_HALFWAY) begin
                next_st.drop_half_event = 1'b1;
            end
        end else begin
            next_st.dropped_frame_tally = drop_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset clears the free-running and dropped-frame counters on the next edge, well inside 160ns

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st                     <= '0;
            st.timer_state         <= TCC_TIMER_HALTED;
            st.timer_preload_value <= `TCC_PRELOAD_RESET;
            st.timer_count         <= `TCC_COUNT_RESET;
            st.swap_word           <= `TCC_SWAP_RESET;
            st.tick_count_value    <= `TCC_FREE_RESET;
            st.dropped_frame_tally <= `TCC_DROP_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register

    assign HOST_DATA_OUT   = st.rdata;
    assign HOST_DATA_OE    = st.data_oe;
    assign TIMER_EVENT     = st.timer_event;
    assign DROP_HALF_EVENT = st.drop_half_event;
    assign LANE_SWAP       = st.lane_swap;
    assign HALF_HIGH       = st.half_high;

endmodule // tcc_regs

`default_nettype wire

// File: hdl/tcc_consts.svh
// offsets, field positions, reset values and rates of the timer and counter registers
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register byte offsets on the host bus
`define TCC_OFS_TIMER_CONFIG        8'h8C
`define TCC_OFS_TIMER_CURRENT_COUNT 8'h90
`define TCC_OFS_WORD_LANE_SWAP      8'h98
`define TCC_OFS_FREE_RUNNING_TICK   8'h9C
`define TCC_OFS_DROPPED_RX_FRAME    8'hA0

// field layout
`define TCC_HALF_W                  16
`define TCC_WORD_W                  32
`define TCC_TIMER_EN_BIT            29
`define TCC_PRELOAD_MSB             15
`define TCC_PRELOAD_LSB             0

// reset and forced values
`define TCC_PRELOAD_RESET           16'hFFFF
`define TCC_COUNT_RESET             16'hFFFF
`define TCC_SWAP_RESET              32'h0000_0000
`define TCC_SWAP_CODE               32'h0FFF_FFFF
`define TCC_FREE_RESET              32'h0000_0000
`define TCC_DROP_RESET              32'h0000_0000
`define TCC_DROP_HALFWAY            32'h8000_0000
`define TCC_TIMER_ZERO              16'h0000

// rates in kHz: system clock and free-running counter rate
`define TCC_SYS_CLK_KHZ             40000
`define TCC_FREE_RUN_KHZ            25000

`endif

// File: hdl/tcc_pkg.sv
// types shared by the timer and counter register block
package tcc_pkg;

    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic [7:1]  addr;
        logic [15:0] wdata;
    } tcc_host_bus_t;

    typedef enum logic [1:0] {
        TCC_TIMER_HALTED  = 2'b01,
        TCC_TIMER_RUNNING = 2'b10
    } tcc_timer_state_t;

    typedef struct packed {
        tcc_timer_state_t timer_state;
        logic [15:0]      timer_preload_value;
        logic             timer_en;
        logic [15:0]      timer_count;
        logic [31:0]      swap_word;
        logic [31:0]      tick_count_value;
        logic [31:0]      tick_snap;
        logic             tick_snap_held;
        logic [31:0]      dropped_frame_tally;
        logic [31:0]      drop_snap;
        logic             drop_snap_held;
        logic             prev_rd;
        logic             prev_wr;
        logic [15:0]      rdata;
        logic             data_oe;
        logic             timer_event;
        logic             drop_half_event;
        logic             lane_swap;
        logic             half_high;
    } tcc_state_t;

endpackage

// File: hdl/tcc_rate_tick.sv
// fractional rate generator: NUM ticks every DEN clock cycles
`timescale 1ns/1ps
`default_nettype none

module tcc_rate_tick #(
    parameter int NUM = 1,
    parameter int DEN = 1
) (
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    output var  logic TICK
);
    localparam int ACC_W = $clog2(DEN + NUM + 1);

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             tick;
    } tcc_tick_state_t;

    tcc_tick_state_t st;
    tcc_tick_state_t next_st;

    initial begin
        if (NUM < 1 || DEN < 1 || NUM > DEN) begin
            $error("tcc_rate_tick: need 1 <= NUM <= DEN");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulate NUM, wrap at DEN; tick gaps differ by at most one cycle, no drift over time
    always_comb begin
        logic [ACC_W-1:0] sum;
        sum     = st.acc + ACC_W'(NUM);
        next_st = st;
        if (sum >= ACC_W'(DEN)) begin
            next_st.acc  = sum - ACC_W'(DEN);
            next_st.tick = 1'b1;
        end else begin
            next_st.acc  = sum;
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign TICK = st.tick;

endmodule // tcc_rate_tick

`default_nettype wire

// File: tb/tcc_regs_monitor.sv
// concurrent checks on the ports of the timer and counter register block
`timescale 1ns/1ps
`default_nettype none
module tcc_regs_monitor #(
    parameter int TIMER_TICK_DIV = 1
) (
    input wire logic                   SYS_CLK,
    input wire logic                   RESET,
    input wire tcc_pkg::tcc_host_bus_t HOST_BUS,
    input wire logic                   RX_FRAME_DROPPED,
    input wire logic [15:0]            HOST_DATA_OUT,
    input wire logic                   HOST_DATA_OE,
    input wire logic                   TIMER_EVENT,
    input wire logic                   DROP_HALF_EVENT,
    input wire logic                   LANE_SWAP,
    input wire logic                   HALF_HIGH
);
    import tcc_pkg::*;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////////
    logic rd_on, wr_on, rd_go, wr_go, rd_q, wr_q;
    assign rd_on = !HOST_BUS.cs_n && !HOST_BUS.rd_n;
    assign wr_on = !HOST_BUS.cs_n && !HOST_BUS.wr_n;
    // a held strobe is one access, so only the first cycle counts
    assign rd_go = rd_on && !rd_q;
    assign wr_go = wr_on && !wr_q;
    always_ff @(posedge SYS_CLK) begin
        rd_q <= RESET ? 1'b0 : rd_on;
        wr_q <= RESET ? 1'b0 : wr_on;
    end
    sequence s_read_taken;
        rd_go;
    endsequence
    sequence s_read_over;
        !rd_on && rd_q;
    endsequence
    sequence s_count_upper;
        rd_go && HOST_BUS.addr[7:2] == 6'h24 ##1 HALF_HIGH;
    endsequence
    read_answer_a: assert property (s_read_taken |=> HOST_DATA_OE) else $error("no data enable after read");
    oe_release_a: assert property (s_read_over |=> !HOST_DATA_OE) else $error("data enable kept after read");
    oe_cause_a: assert property (HOST_DATA_OE |-> $past(rd_on)) else $error("data enable without read");
    data_hold_a: assert property (!rd_go |=> $stable(HOST_DATA_OUT)) else $error("read data moved");
    count_upper_a: assert property (s_count_upper |-> HOST_DATA_OUT == 16'h0000) else $error("count upper set");
    half_select_a: assert property (rd_go || wr_go |=> HALF_HIGH == ($past(HOST_BUS.addr[1]) ^ $past(LANE_SWAP)))
        else $error("wrong half selected");
    swap_cause_a: assert property ($changed(LANE_SWAP) |-> $past(wr_go, 2)) else $error("swap without write");
    drop_cause_a: assert property (DROP_HALF_EVENT |-> $past(RX_FRAME_DROPPED)) else $error("halfway w/o drop");
    drop_pulse_a: assert property (DROP_HALF_EVENT |=> !DROP_HALF_EVENT) else $error("halfway event long");
endmodule // tcc_regs_monitor
bind tcc_regs tcc_regs_monitor #(.TIMER_TICK_DIV(TIMER_TICK_DIV)) u_mon (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .HOST_BUS(HOST_BUS), .RX_FRAME_DROPPED(RX_FRAME_DROPPED), .HOST_DATA_OUT(HOST_DATA_OUT),
    .HOST_DATA_OE(HOST_DATA_OE), .TIMER_EVENT(TIMER_EVENT), .DROP_HALF_EVENT(DROP_HALF_EVENT),
    .LANE_SWAP(LANE_SWAP), .HALF_HIGH(HALF_HIGH));
`default_nettype wire

// File: tb/tcc_host_model.sv
// host processor model driving the half-word register bus
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESET,
    input  wire logic                   HOST_DATA_OE,
    input  wire logic [15:0]            HOST_DATA_OUT,
    output var  tcc_pkg::tcc_host_bus_t HOST_BUS
);
    import tcc_pkg::*;
    tcc_host_bus_t b = '{1'b1, 1'b1, 1'b1, 7'h00, 16'h0000};
    int            since_rst = 0;
    // deselected lines never show the last value
    always_comb begin
        HOST_BUS = b;
        if (b.cs_n) begin
            HOST_BUS.addr = ~b.addr;
            HOST_BUS.wdata = ~b.wdata;
        end
    end
    always @(posedge SYS_CLK) since_rst <= RESET ? 0 : since_rst + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_ready();
        while (since_rst < 8) @(negedge SYS_CLK);
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        wait_ready();
        @(negedge SYS_CLK);
        b = '{1'b0, 1'b0, 1'b1, ofs[7:1], b.wdata};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge SYS_CLK);
            ok = (HOST_DATA_OE === 1'b1);
        end
        d = HOST_DATA_OUT;
        @(negedge SYS_CLK);
        b.cs_n = 1'b1;
        b.rd_n = 1'b1;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [15:0] v);
        wait_ready();
        @(negedge SYS_CLK);
        b = '{1'b0, 1'b1, 1'b0, ofs[7:1], v};
        @(negedge SYS_CLK);
        b.cs_n = 1'b1;
        b.wr_n = 1'b1;
    endtask
endmodule // tcc_host_model
`default_nettype wire

// File: tb/tcc_regs_test.sv
// self-checking testbench for the timer and counter register block
`timescale 1ns/1ps
`default_nettype none
module tcc_regs_test;
    import tcc_pkg::*;
    typedef struct packed { logic any; logic [15:0] v; } tcc_note_t;
    logic          sys_clk = 1'b0;
    logic          reset   = 1'b1;
    logic          rx_drop = 1'b0;
    tcc_host_bus_t host_bus;
    logic [15:0]   data_out, d, h1, l1, h2, l2;
    logic          data_oe, timer_ev, drop_ev, lane_swap, half_high, oe_q;
    int            error_cnt = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    int            ev_cnt = 0;
    int            ev_last, ev_per, p, k, t1, t2;
    tcc_note_t     notes[$];
    tcc_note_t     n;
    always #12.5 sys_clk = ~sys_clk;
    tcc_regs #(.TIMER_TICK_DIV(1)) u_dut (.SYS_CLK(sys_clk), .RESET(reset), .HOST_BUS(host_bus),
        .RX_FRAME_DROPPED(rx_drop), .HOST_DATA_OUT(data_out), .HOST_DATA_OE(data_oe), .TIMER_EVENT(timer_ev),
        .DROP_HALF_EVENT(drop_ev), .LANE_SWAP(lane_swap), .HALF_HIGH(half_high));
    tcc_host_model u_host (.SYS_CLK(sys_clk), .RESET(reset), .HOST_DATA_OE(data_oe),
        .HOST_DATA_OUT(data_out), .HOST_BUS(host_bus));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // any marks a value only the caller can judge
    task automatic rd(input logic [7:0] ofs, input logic any, input logic [15:0] v, output logic [15:0] q);
        bit ok;
        notes.push_back('{any, v});
        u_host.rd(ofs, q, ok);
        if (!ok) begin
            check(0, 1);
            conclude();
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (notes.size() == 0)
                check(1, 0);
            else begin
                n = notes.pop_front();
                if (!n.any)
                    check(data_out, n.v);
            end
        end
        if (timer_ev === 1'b1) begin
            ev_per <= cyc - ev_last;
            ev_last <= cyc;
            ev_cnt <= ev_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        k = $urandom(7);
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 9; i++)
            rd(8'h8C + 2 * i + (i > 3 ? 4 : 0), i == 6, (i == 0 || i == 2) ? 16'hFFFF : 16'h0000, d);
        // free count low half is live; drop counter read above left a snapshot armed, consume it
        rd(8'hA2, 1'b0, 16'h0000, d);
        rd(8'hB4, 1'b0, 16'h0000, d);
        @(negedge sys_clk);
        t1 = cyc;
        rd(8'h9E, 1'b1, 16'h0000, h1);
        rd(8'h9C, 1'b1, 16'h0000, l1);
        repeat (800) @(posedge sys_clk);
        @(negedge sys_clk);
        t2 = cyc;
        rd(8'h9C, 1'b1, 16'h0000, l2);
        rd(8'h9E, 1'b1, 16'h0000, h2);
        k = {h2, l2} - {h1, l1};
        check(k >= (t2 - t1) * 5 / 8 - 1 && k <= (t2 - t1) * 5 / 8 + 1, 1);
        k = 1 + $urandom_range(19);
        repeat (k) begin
            @(negedge sys_clk);
            rx_drop = 1'b1;
            @(negedge sys_clk);
            rx_drop = 1'b0;
            repeat ($urandom_range(3)) @(negedge sys_clk);
        end
        rd(8'hA0, 1'b0, k[15:0], d);
        rd(8'hA2, 1'b0, 16'h0000, d);
        rd(8'hA0, 1'b0, 16'h0000, d);
        u_host.wr(8'h98, 16'hFFFF);
        u_host.wr(8'h9A, 16'h0FFF);
        rd(8'h98, 1'b0, 16'h0FFF, d);
        rd(8'h9A, 1'b0, 16'hFFFF, d);
        rd(8'h8E, 1'b0, 16'hFFFF, d);
        u_host.wr(8'h98, 16'h0000);
        rd(8'h98, 1'b0, 16'hFFFF, d);
        rd(8'h9A, 1'b0, 16'h0000, d);
        p = 8 + $urandom_range(32);
        u_host.wr(8'h8C, p[15:0]);
        u_host.wr(8'h8E, 16'h2000);
        k = ev_cnt;
        for (int i = 0; i < 500 && ev_cnt < k + 3; i++)
            @(posedge sys_clk);
        if (ev_cnt < k + 3) begin
            check(0, 1);
            conclude();
        end
        check(ev_per, p + 1);
        rd(8'h90, 1'b1, 16'h0000, d);
        check(d <= p, 1);
        u_host.wr(8'h8E, 16'h0000);
        rd(8'h8C, 1'b0, 16'hFFFF, d);
        rd(8'h90, 1'b1, 16'h0000, l1);
        k = ev_cnt;
        repeat (100) @(posedge sys_clk);
        rd(8'h90, 1'b0, l1, d);
        check(ev_cnt, k);
        conclude();
    end
endmodule // tcc_regs_test
`default_nettype wire
